// file: hw/tccp_timer.v
// top of the capture/compare/pwm timer: wishbone registers, counter, two channels
// assumes a classic wishbone master on clk_i and asynchronous capture pins
// Operation
// - seven prescaled rates feed the counter
// - select 0..6 divide by 1..64, 7 invalid
// - at period limit set wrap flag, restart
// - active capture edge copies counter to channel
// - edge polarity selectable; capture may interrupt
// - event sets flag; irq only when enabled
// - compare match sets, clears or toggles pin
// - unbuffered compare write takes effect immediately
// - pair select links channels onto pin 0
// - last written pair takes over at wrap
// - paired: ch0 control governs, pin 1 released
// - toggle on wrap forms pwm period
// - compare drives complement of pulse level
// - period is limit plus one ticks
// - pulse width equals compare value ticks
// - clear resets counter and prescaler; halt stops
// - mode 0:1 unbuffered, 1:0 buffered pair
// - action 1:0 clears, 1:1 sets on match
// - no wrap toggle keeps zero duty
// - full duty plus wrap toggle gives 100%
`timescale 1ns/1ns
`default_nettype none
`include "tccp_defs.vh"
module tccp_timer #(
    parameter CW = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire [1:0] cap_pin_i,
    output reg [1:0] cmp_pin_o,
    output reg [1:0] cmp_oe_o,
    output reg wrap_irq_o,
    output reg [1:0] ch_irq_o
);
    // ****************************************
    // register state
    // ****************************************
    reg wrap_flag_r;
    reg wrap_ie_r;
    reg halt_r;
    reg [2:0] ps_r;
    reg [CW-1:0] count_r;
    reg [CW-1:0] limit_r;
    reg [7:0] ctl_r [0:1];
    reg [CW-1:0] val_r [0:1];
    reg [1:0] pin_r;
    reg active_r;
    reg pend_r;
    reg pend_sel_r;
    reg wrap_rd_r;
    reg [1:0] flag_rd_r;
    reg limit_hold_r;
    reg clr_req_r;
    reg [CW-1:0] count_nxt;

    wire tick;
    wire [1:0] rise;
    wire [1:0] fall;
    wire acc = cyc_i & stb_i & ~ack_o;
    wire wr = acc & we_i & ce_i;
    wire rd = acc & ~we_i & ce_i;
    // which channel a control or value access addresses
    wire wc = (adr_i == `TCCP_A_C1CTL);
    wire wv = (adr_i == `TCCP_A_C1VAL);
    wire paired = ctl_r[0][`TCCP_C_MSB];
    wire at_limit = (count_r == limit_r);
    wire wrap_ev = tick & at_limit & ~limit_hold_r;

    tccp_prescaler #(.W(6)) u_ps (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clear_i(clr_req_r),
        .run_i(~halt_r),
        .sel_i(ps_r),
        .tick_o(tick)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_sync
            tccp_capsync u_cs (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .ce_i(ce_i),
                .pin_i(cap_pin_i[g]),
                .rise_o(rise[g]),
                .fall_o(fall[g])
            );
        end
    endgenerate

    // ****************************************
    // counter
    // ****************************************
    always @* begin
        count_nxt = count_r;
        if (clr_req_r)
            count_nxt = {CW{1'b0}};
        else if (tick)
            count_nxt = at_limit ? {CW{1'b0}} : count_r + {{(CW-1){1'b0}}, 1'b1};
    end

    // ****************************************
    // channel event logic
    // ****************************************
    // effective compare value: paired mode uses whichever pair is active
    wire [CW-1:0] cmp0 = paired ? val_r[active_r] : val_r[0];
    wire [1:0] is_out;
    wire [1:0] is_cap;
    wire [1:0] cap_ev;
    wire [1:0] cmp_ev;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            wire [CW-1:0] cv = (g == 0) ? cmp0 : val_r[1];
            wire live = (g == 0) | ~paired;
            wire [1:0] ms = {ctl_r[g][`TCCP_C_MSB], ctl_r[g][`TCCP_C_MSA]};
            wire [1:0] el = {ctl_r[g][`TCCP_C_ELSB], ctl_r[g][`TCCP_C_ELSA]};
            assign is_out[g] = live & (ms != 2'b00) & (el != 2'b00);
            assign is_cap[g] = live & (ms == 2'b00);
            // els 01 rising, 10 falling, 11 both
            assign cap_ev[g] = is_cap[g] & ((el[0] & rise[g]) | (el[1] & fall[g]));
            // match as the counter steps onto the value, so the pulse lasts cv ticks
            assign cmp_ev[g] = (live & (ms != 2'b00)) & tick & ~clr_req_r &
                (count_nxt == cv);
        end
    endgenerate

    // ****************************************
    // main clocked process
    // ****************************************
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wrap_flag_r <= 1'b0;
            wrap_ie_r <= 1'b0;
            halt_r <= 1'b1;
            ps_r <= 3'h0;
            count_r <= {CW{1'b0}};
            limit_r <= `TCCP_RST_LIMIT;
            ctl_r[0] <= 8'h00;
            ctl_r[1] <= 8'h00;
            val_r[0] <= {CW{1'b0}};
            val_r[1] <= {CW{1'b0}};
            pin_r <= 2'b00;
            active_r <= 1'b0;
            pend_r <= 1'b0;
            pend_sel_r <= 1'b0;
            wrap_rd_r <= 1'b0;
            flag_rd_r <= 2'b00;
            limit_hold_r <= 1'b0;
            clr_req_r <= 1'b0;
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
            cmp_pin_o <= 2'b00;
            cmp_oe_o <= 2'b00;
            wrap_irq_o <= 1'b0;
            ch_irq_o <= 2'b00;
        end else if (ce_i) begin
            ack_o <= acc;
            clr_req_r <= 1'b0;
            count_r <= count_nxt;
            // ****************************************
            // wrap: flag, pair swap, toggle
            // ****************************************
            if (wrap_ev) begin
                wrap_flag_r <= 1'b1;
                if (paired && pend_r) begin
                    active_r <= pend_sel_r;
                    pend_r <= 1'b0;
                end
            end
            for (i = 0; i < 2; i = i + 1) begin
                if (is_out[i]) begin
                    if (wrap_ev && ctl_r[i][`TCCP_C_TOV])
                        pin_r[i] <= ~pin_r[i];
                    if (cmp_ev[i]) begin
                        case ({ctl_r[i][`TCCP_C_ELSB], ctl_r[i][`TCCP_C_ELSA]})
                            2'b01: pin_r[i] <= ~pin_r[i];
                            2'b10: pin_r[i] <= 1'b0;
                            2'b11: pin_r[i] <= 1'b1;
                            default: pin_r[i] <= pin_r[i];
                        endcase
                    end
                    // full duty: hold the wrap level so compares never end the pulse
                    if (ctl_r[i][`TCCP_C_MAX] && ctl_r[i][`TCCP_C_TOV])
                        pin_r[i] <= ~ctl_r[i][`TCCP_C_ELSA];
                end
                if (cap_ev[i])
                    val_r[i] <= count_r;
                if (cap_ev[i] | cmp_ev[i])
                    ctl_r[i][`TCCP_C_FLAG] <= 1'b1;
            end
            // ****************************************
            // register reads (arm two-step flag clears)
            // ****************************************
            if (rd) begin
                case (adr_i)
                    `TCCP_A_TCTRL: begin
                        dat_o <= {24'h000000, wrap_flag_r, wrap_ie_r, halt_r, 2'b00, ps_r};
                        wrap_rd_r <= wrap_flag_r;
                    end
                    `TCCP_A_COUNT: dat_o <= {{(32-CW){1'b0}}, count_r};
                    `TCCP_A_LIMIT: dat_o <= {{(32-CW){1'b0}}, limit_r};
                    `TCCP_A_C0CTL: begin
                        dat_o <= {24'h000000, ctl_r[0]};
                        flag_rd_r[0] <= ctl_r[0][`TCCP_C_FLAG];
                    end
                    `TCCP_A_C0VAL: dat_o <= {{(32-CW){1'b0}}, val_r[0]};
                    `TCCP_A_C1CTL: begin
                        dat_o <= {24'h000000, ctl_r[1]};
                        flag_rd_r[1] <= ctl_r[1][`TCCP_C_FLAG];
                    end
                    `TCCP_A_C1VAL: dat_o <= {{(32-CW){1'b0}}, val_r[1]};
                    `TCCP_A_PINS: dat_o <= {28'h0000000, pin_r, cmp_oe_o};
                    default: dat_o <= 32'h00000000;
                endcase
            end
            // ****************************************
            // register writes
            // ****************************************
            if (wr) begin
                case (adr_i)
                    `TCCP_A_TCTRL: if (sel_i[0]) begin
                        // clear needs read-then-write-0, and a new wrap this cycle wins
                        if (!dat_i[`TCCP_T_WRAP] && wrap_rd_r && !wrap_ev)
                            wrap_flag_r <= 1'b0;
                        wrap_rd_r <= 1'b0;
                        wrap_ie_r <= dat_i[`TCCP_T_WIE];
                        halt_r <= dat_i[`TCCP_T_HALT];
                        clr_req_r <= dat_i[`TCCP_T_CLEAR];
                        ps_r <= dat_i[`TCCP_T_PS_HI:`TCCP_T_PS_LO];
                    end
                    `TCCP_A_LIMIT: begin
                        if (sel_i[1]) begin
                            limit_r[15:8] <= dat_i[15:8];
                            limit_hold_r <= ~sel_i[0];
                        end
                        if (sel_i[0]) begin
                            limit_r[7:0] <= dat_i[7:0];
                            limit_hold_r <= 1'b0;
                        end
                    end
                    `TCCP_A_C0CTL, `TCCP_A_C1CTL: if (sel_i[0]) begin
                        ctl_r[wc][6:0] <= dat_i[6:0];
                        if (!dat_i[`TCCP_C_FLAG] && flag_rd_r[wc] && !(cap_ev[wc] | cmp_ev[wc]))
                            ctl_r[wc][`TCCP_C_FLAG] <= 1'b0;
                        flag_rd_r[wc] <= 1'b0;
                        if (!wc && !dat_i[`TCCP_C_MSB]) begin
                            active_r <= 1'b0;
                            pend_r <= 1'b0;
                        end
                    end
                    `TCCP_A_C0VAL, `TCCP_A_C1VAL: begin
                        if (sel_i[1])
                            val_r[wv][15:8] <= dat_i[15:8];
                        if (sel_i[0])
                            val_r[wv][7:0] <= dat_i[7:0];
                        if (paired) begin
                            pend_r <= 1'b1;
                            pend_sel_r <= wv;
                        end
                    end
                    default: ;
                endcase
            end
            // ****************************************
            // registered outputs
            // ****************************************
            cmp_pin_o <= pin_r;
            cmp_oe_o <= is_out;
            wrap_irq_o <= wrap_flag_r & wrap_ie_r;
            ch_irq_o[0] <= ctl_r[0][`TCCP_C_FLAG] & ctl_r[0][`TCCP_C_IE];
            ch_irq_o[1] <= ctl_r[1][`TCCP_C_FLAG] & ctl_r[1][`TCCP_C_IE] & ~paired;
        end
    end
endmodule
`default_nettype wire

// file: include/tccp_defs.vh
// register offsets, field positions and reset values for the capture/compare timer
// assumes a 32-bit wishbone slave with one aligned word per register
`ifndef TCCP_DEFS_VH
`define TCCP_DEFS_VH

// ****************************************
// register byte addresses
// ****************************************
`define TCCP_A_TCTRL 8'h00
`define TCCP_A_COUNT 8'h04
`define TCCP_A_LIMIT 8'h08
`define TCCP_A_C0CTL 8'h0c
`define TCCP_A_C0VAL 8'h10
`define TCCP_A_C1CTL 8'h14
`define TCCP_A_C1VAL 8'h18
`define TCCP_A_PINS 8'h1c

// ****************************************
// timer_control fields
// ****************************************
`define TCCP_T_WRAP 7
`define TCCP_T_WIE 6
`define TCCP_T_HALT 5
`define TCCP_T_CLEAR 4
`define TCCP_T_PS_HI 2
`define TCCP_T_PS_LO 0

// ****************************************
// channel control fields
// ****************************************
`define TCCP_C_FLAG 7
`define TCCP_C_IE 6
`define TCCP_C_MSB 5
`define TCCP_C_MSA 4
`define TCCP_C_ELSB 3
`define TCCP_C_ELSA 2
`define TCCP_C_TOV 1
`define TCCP_C_MAX 0

// ****************************************
// reset values
// ****************************************
`define TCCP_RST_LIMIT 16'hffff
`define TCCP_RST_TCTRL 8'h20
`define TCCP_PS_BAD 3'h7

`endif

// file: hw/tccp_prescaler.v
// prescaler: divides the bus clock into seven counting rates
// assumes clear and enable come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "tccp_defs.vh"
module tccp_prescaler #(
    parameter W = 6
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire clear_i,
    input wire run_i,
    input wire [2:0] sel_i,
    output reg tick_o
);
    reg [W-1:0] div_r;
    wire [W-1:0] mask;
    // mask of low bits that must all be one for a tick at divide 2^sel
    assign mask = ~({W{1'b1}} << sel_i);

    always @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= {W{1'b0}};
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (clear_i || !run_i) begin
                if (clear_i)
                    div_r <= {W{1'b0}};
                tick_o <= 1'b0;
            end else begin
                div_r <= div_r + {{(W-1){1'b0}}, 1'b1};
                // select 111 gives no tick at all
                tick_o <= (sel_i != `TCCP_PS_BAD) && ((div_r & mask) == mask);
            end
        end
    end
endmodule
`default_nettype wire

// file: hw/tccp_capsync.v
// three-stage pin synchroniser with edge detect for one capture pin
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ns
`default_nettype none
module tccp_capsync (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire pin_i,
    output reg rise_o,
    output reg fall_o
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // s1 feeds only s2; edges need s2 and s3 to disagree, i.e. a settled change
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else if (ce_i) begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            rise_o <= s2_r & ~s3_r;
            fall_o <= ~s2_r & s3_r;
        end
    end
endmodule
`default_nettype wire

// file: bench/tccp_timer_checker.sv
// port assertions for the capture/compare timer
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module tccp_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [1:0] cmp_pin_o,
    input wire logic [1:0] cmp_oe_o,
    input wire logic wrap_irq_o,
    input wire logic [1:0] ch_irq_o
);
    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic rd = ack_o && !we_i;
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
        else $error("ack missing after a bus request");
    a_ack_single: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_unmapped_zero: assert property (rd && adr_i >= 8'h20 |-> dat_o == 32'h0)
        else $error("unmapped read returned data");
    a_clear_reads0: assert property (rd && adr_i == 8'h00 |-> !dat_o[4])
        else $error("counter clear bit read back as one");
    a_count_width: assert property (rd && adr_i == 8'h04 |-> dat_o[31:16] == 16'h0)
        else $error("counter wider than sixteen bits");
    a_ch_irq_link: assert property (rd && adr_i == 8'h0c |->
        ##[0:2] (ch_irq_o[0] == (dat_o[7] && dat_o[6])))
        else $error("channel irq disagrees with flag and enable");
    a_wrap_irq_link: assert property (rd && adr_i == 8'h00 |->
        ##[0:2] (wrap_irq_o == (dat_o[7] && dat_o[6])))
        else $error("wrap irq disagrees with flag and enable");
    a_pair_release: assert property (rd && adr_i == 8'h0c && dat_o[5] |->
        ##[0:2] (!cmp_oe_o[1] && !ch_irq_o[1]))
        else $error("channel 1 still active while paired");
    a_oe_drive: assert property (rd && adr_i == 8'h0c && dat_o[5:4] != 2'b00 &&
        dat_o[3:2] != 2'b00 |-> ##[0:2] cmp_oe_o[0])
        else $error("compare pin not driven in output mode");
    a_freeze_hold: assert property (!ce_i |=> $stable(cmp_pin_o) && $stable(ack_o))
        else $error("outputs moved while clock enable low");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o &&
        cmp_oe_o == 2'b00 && !wrap_irq_o && ch_irq_o == 2'b00)
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// file: bench/tccp_pin_model.sv
// far side pins: drives capture inputs, measures period and high time on pin 0
// assumes the pwm pin changes only on clk_i edges
`timescale 1ns/1ns
`default_nettype none
module tccp_pin_model (
    input wire logic clk_i,
    input wire logic pwm_i,
    output logic [1:0] cap_o,
    output logic [15:0] hi_o,
    output logic [15:0] per_o
);
    logic [15:0] hc;
    logic [15:0] pc;
    logic last;
    initial begin
        cap_o = 2'b00;
        {hi_o, per_o, hc, pc, last} = '0;
    end
    // figures latch on each rising edge, so the first period after setup is partial
    always @(posedge clk_i) begin
        last <= pwm_i;
        if (pwm_i && !last) begin
            per_o <= pc;
            hi_o <= hc;
            pc <= 16'h1;
            hc <= 16'h1;
        end else begin
            pc <= pc + 16'h1;
            hc <= hc + {15'h0, pwm_i};
        end
    end
    // pins are held for eight cycles so the three-flop synchroniser sees each level
    task automatic edge_to(input int ch, input logic lvl);
        @(posedge clk_i);
        cap_o[ch] <= lvl;
        repeat (8) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// file: bench/tccp_testbench.sv
// self-checking bench for the capture/compare timer
// assumes the timer top, its defines header and the pin model
`timescale 1ns/1ns
`default_nettype none
`include "tccp_defs.vh"
module testbench;
    logic clk, rst, ce, cyc, stb, we, ack, wirq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dw, dr, q, q0;
    logic [1:0] cap, pin, oe, chirq;
    logic [15:0] hi, per;
    int n_fail = 0;
    int checks_done = 0;
    int lim, v, h;
    tccp_timer uut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw), .dat_o(dr), .ack_o(ack),
        .cap_pin_i(cap), .cmp_pin_o(pin), .cmp_oe_o(oe), .wrap_irq_o(wirq),
        .ch_irq_o(chirq));
    tccp_pin_model pm (.clk_i(clk), .pwm_i(pin[0]), .cap_o(cap), .hi_o(hi), .per_o(per));
    // ****************************************
    // tasks
    // ****************************************
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk);
        {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = dr;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic highs(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            c += int'(pin[0] === 1'b1);
        end
    endtask
    task automatic settle;
        repeat (4 * lim) @(posedge clk);
    endtask
    function automatic logic [31:0] ticks(input int span, input int ps);
        return span >> ps;
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial begin
        #1000000;
        n_fail++;
        wrap_up();
    end
    initial begin
        {rst, ce, cyc, stb, we, adr, sel, dw} = {2'b11, 3'b000, 8'h0, 4'hf, 32'h0};
        q = $urandom(23357);
        repeat (2) @(posedge clk);
        rst <= 0;
        rd(`TCCP_A_TCTRL, q);
        chk("tctrl reset", `TCCP_RST_TCTRL, q);
        rd(`TCCP_A_LIMIT, q);
        chk("limit reset", `TCCP_RST_LIMIT, q);
        rd(8'h40, q);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
        // reads 128 cycles apart, so every divider sees a whole number of ticks
        for (int ps = 0; ps < 7; ps++) begin
            wr(`TCCP_A_TCTRL, 32'h30 | ps);
            wr(`TCCP_A_TCTRL, ps);
            rd(`TCCP_A_COUNT, q0);
            repeat (125) @(posedge clk);
            rd(`TCCP_A_COUNT, q);
            chk("count step", ticks(128, ps), q - q0);
        end
        wr(`TCCP_A_TCTRL, 32'h20);
        rd(`TCCP_A_COUNT, q0);
        repeat (60) @(posedge clk);
        rd(`TCCP_A_COUNT, q);
        chk("halted count", q0, q);
        $display("test prescaler done");
        wr(`TCCP_A_C1CTL, 32'h48);
        pm.edge_to(1, 1'b1);
        rd(`TCCP_A_C1CTL, q);
        chk("rise ignored", 32'h0, q[7]);
        pm.edge_to(1, 1'b0);
        rd(`TCCP_A_C1CTL, q);
        chk("capture flag", 32'h1, q[7]);
        chk("capture irq", 32'h1, chirq[1]);
        rd(`TCCP_A_C1VAL, q);
        chk("capture value", q0, q);
        wr(`TCCP_A_C1CTL, 32'h08);
        rd(`TCCP_A_C1CTL, q);
        chk("flag cleared", 32'h0, {q[7], chirq[1]});
        $display("test capture done");
        for (int k = 0; k < 2; k++) begin
            lim = $urandom_range(20, 60);
            v = $urandom_range(2, lim - 2);
            wr(`TCCP_A_TCTRL, 32'h30);
            wr(`TCCP_A_LIMIT, lim);
            wr(`TCCP_A_C0VAL, v);
            wr(`TCCP_A_C0CTL, k ? 32'h5e : 32'h5a);
            wr(`TCCP_A_TCTRL, 32'h40);
            settle();
            chk("period", lim + 1, per);
            chk("pulse", k ? lim + 1 - v : v, hi);
            rd(`TCCP_A_TCTRL, q);
            chk("wrap flag", 32'h1, q[7]);
            rd(`TCCP_A_C0CTL, q);
            chk("compare flag", 32'h1, q[7]);
        end
        wr(`TCCP_A_C0CTL, 32'h18);
        settle();
        highs(2 * lim, h);
        chk("zero duty", 32'h0, h);
        wr(`TCCP_A_C0CTL, 32'h1b);
        settle();
        highs(2 * lim, h);
        chk("full duty", 2 * lim, h);
        $display("test pwm done");
        // the first width goes to the pair driving the pin; later ones only to the pair that is not
        wr(`TCCP_A_TCTRL, 32'h30);
        v = $urandom_range(2, lim - 2);
        wr(`TCCP_A_C0VAL, v);
        wr(`TCCP_A_C0CTL, 32'h2a);
        wr(`TCCP_A_TCTRL, 32'h00);
        settle();
        chk("pair first", v, hi);
        v = $urandom_range(2, lim - 2);
        wr(`TCCP_A_C1VAL, v);
        settle();
        chk("pair swap", v, hi);
        rd(`TCCP_A_C0CTL, q);
        chk("pin 1 released", 32'h0, oe[1]);
        v = $urandom_range(2, lim - 2);
        wr(`TCCP_A_C0VAL, v);
        settle();
        chk("pair back", v, hi);
        @(posedge clk);
        ce <= 0;
        repeat (5) @(posedge clk);
        ce <= 1;
        $display("test paired done");
        wrap_up();
    end
endmodule
bind tccp_timer tccp_chk chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .cmp_pin_o(cmp_pin_o), .cmp_oe_o(cmp_oe_o), .wrap_irq_o(wrap_irq_o),
    .ch_irq_o(ch_irq_o));
`default_nettype wire
